// ==== rtl/cbk_bank.sv ====
// charger register bank with two-wire target, watchdog, safety timers and alert pin
// assumes core status inputs come from logic on sys_clk; bus pins are asynchronous
//
// Function
// - status bits 7/6 flag safety timer expiry
// - status bit 5 flags watchdog expiry
// - bits 4/3 report battery lockout, short
// - bits 2:1 report charge phase code
// - bit 0 set while input supply good
// - three-bit thermistor zone read-only field
// - mask register at 02H suppresses interrupt sources
// - two-bit battery lockout threshold select
// - current scale bit multiplies charge currents
// - two-bit discharge current limit code
// - two-bit battery switch mode field
// - three-bit trickle/termination current code, reset 001
// - five-bit cv target code, reset 00100
// - charging only while enable bit set
// - trickle threshold select bit, reset one
// - six-bit constant current code, reset 000100
// - writing kick bit restarts the watchdog
// - watchdog runs only while enabled
// - thermistor sensing powered only when enabled
// - trickle safety timer runs when enabled
// - termination bit stops charge at end
// - three-bit system voltage floor code
// - alert pin low 256 us per event
// - watchdog expiry: paths off, then defaults
`timescale 1ns/10ps
module cbk_bank #(
	parameter int TICK_CYCLES = cbk_pkg::TICK_CYC,
	parameter int WDOG_TICKS  = cbk_pkg::WDOG_TK,
	parameter int OFF_TICKS   = cbk_pkg::OFF_TK,
	parameter int TRI_TICKS   = cbk_pkg::TRI_TK,
	parameter int FAST_TICKS  = cbk_pkg::FAST_TK,
	parameter int IRQ_CYCLES  = cbk_pkg::IRQ_CYC
) (
	input  wire logic              sys_clk,        // logic clock
	input  wire logic              srst,           // sync reset
	input  wire logic              bus_clk,        // two-wire clock pin
	input  wire logic              bus_data_in,    // data pin level
	output logic                   bus_data_out,   // data drive level
	output logic                   bus_data_oe,    // data pull low
	output logic                   host_alert_out, // alert drive level
	output logic                   host_alert_oe,  // alert pull low
	input  wire cbk_pkg::cbk_core_t core,          // charger status
	output cbk_pkg::cbk_cfg_t      cfg             // charger controls
);
	import cbk_pkg::*;

	typedef enum logic [8:0] {
		I_IDLE = 9'b0_0000_0001,
		I_ADDR = 9'b0_0000_0010,
		I_ACKA = 9'b0_0000_0100,
		I_PTR  = 9'b0_0000_1000,
		I_ACKP = 9'b0_0001_0000,
		I_WR   = 9'b0_0010_0000,
		I_ACKW = 9'b0_0100_0000,
		I_RD   = 9'b0_1000_0000,
		I_RACK = 9'b1_0000_0000
	} cbk_i2c_t;

	typedef struct packed {
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		cbk_i2c_t    bus;
		logic [3:0]  bits;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic        rw;
		logic        nack;
		logic        oe;
		logic [7:0]  mask;
		logic [7:0]  ctl0;
		logic [7:0]  ctl1;
		logic [7:0]  ctl2;
		logic [7:0]  ctl3;
		logic [7:0]  stat;
		logic [2:0]  zone;
		logic        tri_to;
		logic        fast_to;
		logic        wd_to;
		logic [31:0] pre;
		logic [31:0] wd_cnt;
		logic [31:0] tri_cnt;
		logic [31:0] fast_cnt;
		logic [31:0] off_cnt;
		logic        off;
		logic [31:0] irq_cnt;
		logic        alert;
		logic        zero;
		cbk_cfg_t    cfg;
	} cbk_state_t;

	cbk_state_t cur_ff;
	cbk_state_t nxt_cur;

	// ****************************
	// register read decode
	// ****************************
	function automatic logic [7:0] rd_reg(input cbk_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_STAT0: v = s.stat;
			OFS_ZONE:  v = {5'h00, s.zone};
			OFS_MASK:  v = s.mask;
			OFS_CTL0:  v = s.ctl0;
			OFS_CTL1:  v = s.ctl1;
			OFS_CTL2:  v = s.ctl2;
			OFS_CTL3:  v = {1'b0, s.ctl3[6:0]};  // kick reads back zero
			default:   v = 8'h00;
		endcase
		return v;
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic sda_v;
	logic kick;
	logic tick;
	logic [6:0] ev;
	logic [7:0] wdat;

	// ****************************
	// next state
	// ****************************
	always_comb begin
		nxt_cur  = cur_ff;
		kick     = 1'b0;
		wdat     = cur_ff.sh;
		// only the second and third stages feed logic
		nxt_cur.scl_s = {cur_ff.scl_s[1:0], bus_clk};
		nxt_cur.sda_s = {cur_ff.sda_s[1:0], bus_data_in};
		sda_v    = cur_ff.sda_s[1];
		scl_rise = cur_ff.scl_s[1] & ~cur_ff.scl_s[2];
		scl_fall = ~cur_ff.scl_s[1] & cur_ff.scl_s[2];
		start_c  = cur_ff.scl_s[1] & cur_ff.scl_s[2] & ~sda_v & cur_ff.sda_s[2];
		stop_c   = cur_ff.scl_s[1] & cur_ff.scl_s[2] & sda_v & ~cur_ff.sda_s[2];

		// two-wire target: shift on rise, drive on fall
		if (scl_rise) begin
			nxt_cur.sh   = {cur_ff.sh[6:0], sda_v};
			nxt_cur.bits = cur_ff.bits + 4'h1;
			if (cur_ff.bus == I_RACK) begin
				nxt_cur.nack = sda_v;
			end
		end
		if (start_c) begin
			nxt_cur.bus  = I_ADDR;
			nxt_cur.bits = 4'h0;
			nxt_cur.oe   = 1'b0;
		end else if (stop_c) begin
			nxt_cur.bus = I_IDLE;
			nxt_cur.oe  = 1'b0;
		end else if (scl_fall) begin
			case (cur_ff.bus)
				I_ADDR: begin
					if (cur_ff.bits == 4'h8) begin
						if (cur_ff.sh[7:1] == TGT_ADDR) begin
							nxt_cur.bus = I_ACKA;
							nxt_cur.rw  = cur_ff.sh[0];
							nxt_cur.oe  = 1'b1;
						end else begin
							nxt_cur.bus = I_IDLE;
						end
					end
				end
				I_ACKA: begin
					nxt_cur.bits = 4'h0;
					if (cur_ff.rw) begin
						nxt_cur.bus = I_RD;
						nxt_cur.sh  = rd_reg(cur_ff, cur_ff.ptr);
						nxt_cur.oe  = ~rd_reg(cur_ff, cur_ff.ptr) >> 7 == 8'h00 ? 1'b0 : 1'b1;
						nxt_cur.ptr = cur_ff.ptr + 8'h01;
					end else begin
						nxt_cur.bus = I_PTR;
						nxt_cur.oe  = 1'b0;
					end
				end
				I_PTR: begin
					if (cur_ff.bits == 4'h8) begin
						nxt_cur.ptr = cur_ff.sh;
						nxt_cur.bus = I_ACKP;
						nxt_cur.oe  = 1'b1;
					end
				end
				I_ACKP, I_ACKW: begin
					nxt_cur.bus  = I_WR;
					nxt_cur.bits = 4'h0;
					nxt_cur.oe   = 1'b0;
				end
				I_WR: begin
					if (cur_ff.bits == 4'h8) begin
						if (cur_ff.ptr == OFS_CTL3 && wdat[B_KICK]) begin
							kick = 1'b1;
						end
						if (cur_ff.ptr == OFS_MASK) begin
							nxt_cur.mask = wdat;
						end
						if (cur_ff.ptr == OFS_CTL0) begin
							nxt_cur.ctl0 = wdat;
						end
						if (cur_ff.ptr == OFS_CTL1) begin
							nxt_cur.ctl1 = wdat;
						end
						if (cur_ff.ptr == OFS_CTL2) begin
							nxt_cur.ctl2 = wdat;
						end
						if (cur_ff.ptr == OFS_CTL3) begin
							nxt_cur.ctl3 = {1'b0, wdat[6:0]};
						end
						nxt_cur.ptr = cur_ff.ptr + 8'h01;
						nxt_cur.bus = I_ACKW;
						nxt_cur.oe  = 1'b1;
					end
				end
				I_RD: begin
					if (cur_ff.bits == 4'h8) begin
						nxt_cur.bus  = I_RACK;
						nxt_cur.bits = 4'h0;
						nxt_cur.oe   = 1'b0;
					end else begin
						// the shifter moves on every rise, so the next bit is always on top
						nxt_cur.oe = ~cur_ff.sh[7];
					end
				end
				I_RACK: begin
					nxt_cur.bits = 4'h0;
					if (cur_ff.nack) begin
						nxt_cur.bus = I_IDLE;
						nxt_cur.oe  = 1'b0;
					end else begin
						nxt_cur.bus = I_RD;
						nxt_cur.sh  = rd_reg(cur_ff, cur_ff.ptr);
						nxt_cur.oe  = ~rd_reg(cur_ff, cur_ff.ptr) >> 7 == 8'h00 ? 1'b0 : 1'b1;
						nxt_cur.ptr = cur_ff.ptr + 8'h01;
					end
				end
				I_IDLE: begin
					nxt_cur.oe = 1'b0;
				end
				default: begin
					nxt_cur.bus = I_IDLE;
					nxt_cur.oe  = 1'b0;
				end
			endcase
		end

		// millisecond prescaler shared by all long timers
		tick = (cur_ff.pre == 32'(TICK_CYCLES - 1));
		nxt_cur.pre = tick ? 32'h0000_0000 : cur_ff.pre + 32'h0000_0001;

		if (kick || cur_ff.off) begin
			nxt_cur.wd_cnt = 32'h0000_0000;
		end else if (cur_ff.ctl3[B_WD_ON] && tick) begin
			nxt_cur.wd_cnt = cur_ff.wd_cnt + 32'h0000_0001;
		end
		// expiry flag, cleared by a kick
		if (kick) begin
			nxt_cur.wd_to = 1'b0;
		end
		if (!cur_ff.off && cur_ff.ctl3[B_WD_ON] && tick && cur_ff.wd_cnt == 32'(WDOG_TICKS - 1)) begin
			nxt_cur.wd_to = 1'b1;
			nxt_cur.off   = 1'b1;
		end
		// system reset mode also powers down
		if (!cur_ff.off && cur_ff.ctl0[1:0] == SW_SYSRST) begin
			nxt_cur.off = 1'b1;
		end
		// after the off period all controls default
		if (cur_ff.off) begin
			if (tick) begin
				nxt_cur.off_cnt = cur_ff.off_cnt + 32'h0000_0001;
			end
			if (tick && cur_ff.off_cnt == 32'(OFF_TICKS - 1)) begin
				nxt_cur.off     = 1'b0;
				nxt_cur.off_cnt = 32'h0000_0000;
				nxt_cur.mask    = RST_MASK;
				nxt_cur.ctl0    = RST_CTL0;
				nxt_cur.ctl1    = RST_CTL1;
				nxt_cur.ctl2    = RST_CTL2;
				nxt_cur.ctl3    = RST_CTL3;
			end
		end

		// trickle timer runs when enabled in trickle
		if (core.phase == PH_TRI && cur_ff.ctl3[B_TRI_EN] && cur_ff.cfg.charge_run) begin
			if (tick) begin
				nxt_cur.tri_cnt = cur_ff.tri_cnt + 32'h0000_0001;
			end
			if (tick && cur_ff.tri_cnt == 32'(TRI_TICKS - 1)) begin
				nxt_cur.tri_to = 1'b1;
			end
		end else begin
			nxt_cur.tri_cnt = 32'h0000_0000;
		end
		// fast timer covers cc/cv and charging past end
		if ((core.phase == PH_CC || core.phase == PH_EOC) && cur_ff.cfg.charge_run) begin
			if (tick) begin
				nxt_cur.fast_cnt = cur_ff.fast_cnt + 32'h0000_0001;
			end
			if (tick && cur_ff.fast_cnt == 32'(FAST_TICKS - 1)) begin
				nxt_cur.fast_to = 1'b1;
			end
		end else begin
			nxt_cur.fast_cnt = 32'h0000_0000;
		end
		// trickle and fast timeouts clear when charging is switched off
		if (!cur_ff.ctl2[B_CHG_EN]) begin
			nxt_cur.tri_to  = 1'b0;
			nxt_cur.fast_to = 1'b0;
		end

		nxt_cur.stat = {nxt_cur.tri_to, nxt_cur.fast_to, nxt_cur.wd_to,
			core.bat_low, core.sys_short, core.phase, core.pgood};
		// zone held while sensing is unpowered
		// zone code passed through as read
		if (cur_ff.ctl3[B_NTC_ON]) begin
			nxt_cur.zone = core.zone;
		end

		// events, bit order matches the mask register
		ev[6] = nxt_cur.stat[4] & ~cur_ff.stat[4];
		ev[5] = (core.phase == PH_EOC) & (cur_ff.stat[2:1] != PH_EOC);
		ev[4] = nxt_cur.stat[3] & ~cur_ff.stat[3];
		ev[3] = nxt_cur.stat[2:1] != cur_ff.stat[2:1];
		ev[2] = nxt_cur.stat[0] != cur_ff.stat[0];
		ev[1] = |(nxt_cur.stat[7:5] & ~cur_ff.stat[7:5]);
		ev[0] = nxt_cur.zone != cur_ff.zone;
		// fixed-length low pulse, retriggered by new events
		if (|(ev & ~cur_ff.mask[6:0])) begin
			nxt_cur.irq_cnt = 32'(IRQ_CYCLES);
		end else if (cur_ff.irq_cnt != 32'h0000_0000) begin
			nxt_cur.irq_cnt = cur_ff.irq_cnt - 32'h0000_0001;
		end
		// pin level kept in its own flop so the output is glitch free
		nxt_cur.alert = (nxt_cur.irq_cnt != 32'h0000_0000);

		// threshold, scale, limit and mode to the core
		nxt_cur.cfg.ctl0 = nxt_cur.ctl0;
		nxt_cur.cfg.ctl1 = nxt_cur.ctl1;
		nxt_cur.cfg.slow_phase_threshold_select = nxt_cur.ctl2[6];
		nxt_cur.cfg.fast_current_code = nxt_cur.ctl2[5:0];
		nxt_cur.cfg.thermistor_sense_on = nxt_cur.ctl3[B_NTC_ON];
		nxt_cur.cfg.power_paths_off     = nxt_cur.off;
		// termination stop at end of charge
		nxt_cur.cfg.charge_run = nxt_cur.ctl2[B_CHG_EN] & ~nxt_cur.off & ~nxt_cur.tri_to
			& ~nxt_cur.fast_to & ~(nxt_cur.ctl3[B_TERM] & core.phase == PH_EOC);
		// floor code stays in control byte 3; cfg carries no copy of it
		nxt_cur.zero = 1'b0;
	end

	// ****************************
	// state register
	// ****************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nxt_cur_reset();
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	task automatic nxt_cur_reset();
		cur_ff      <= '0;
		cur_ff.scl_s <= 3'h7;
		cur_ff.sda_s <= 3'h7;
		cur_ff.bus  <= I_IDLE;
		cur_ff.ctl1 <= RST_CTL1;
		cur_ff.ctl2 <= RST_CTL2;
		cur_ff.ctl3 <= RST_CTL3;
		cur_ff.zone <= RST_ZONE;
		cur_ff.cfg  <= '{ctl0: RST_CTL0, ctl1: RST_CTL1, fast_current_code: RST_CTL2[5:0],
			slow_phase_threshold_select: RST_CTL2[6], charge_run: 1'b0,
			thermistor_sense_on: 1'b0, power_paths_off: 1'b0};
	endtask

	// outputs straight from the state flops
	assign bus_data_out   = cur_ff.zero;
	assign bus_data_oe    = cur_ff.oe;
	assign host_alert_out = cur_ff.zero;
	assign host_alert_oe  = cur_ff.alert;
	assign cfg            = cur_ff.cfg;

	// ****************************
	// checks
	// ****************************
	sequence s_kick_write;
		kick ##1 1'b1;
	endsequence

	chk_kick_restart: assert property (@(posedge sys_clk) disable iff (srst)
		s_kick_write |-> cur_ff.wd_cnt == 32'h0000_0000 && !cur_ff.wd_to)
		else $error("kick did not restart watchdog");
	chk_wdog_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!cur_ff.ctl3[B_WD_ON] && !kick && !cur_ff.off |=> $stable(cur_ff.wd_cnt))
		else $error("watchdog counted while disabled");
	chk_wdog_expire: assert property (@(posedge sys_clk) disable iff (srst)
		!cur_ff.off && cur_ff.ctl3[B_WD_ON] && tick && cur_ff.wd_cnt == 32'(WDOG_TICKS - 1)
		|=> cur_ff.off && cur_ff.wd_to ##1 cfg.power_paths_off)
		else $error("watchdog expiry missed");
	chk_charge_gate: assert property (@(posedge sys_clk) disable iff (srst)
		!cur_ff.ctl2[B_CHG_EN] |-> !cfg.charge_run)
		else $error("charging while disabled");
	chk_term_stop: assert property (@(posedge sys_clk) disable iff (srst)
		cur_ff.ctl3[B_TERM] && cur_ff.stat[2:1] == PH_EOC |-> !cfg.charge_run)
		else $error("charge not stopped at end");
	chk_pgood_follow: assert property (@(posedge sys_clk) disable iff (srst)
		1'b1 |=> cur_ff.stat[0] == $past(core.pgood) && cur_ff.stat[2:1] == $past(core.phase))
		else $error("status does not follow core");
	chk_zone_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!cur_ff.ctl3[B_NTC_ON] |=> $stable(cur_ff.zone))
		else $error("zone changed while unpowered");
	chk_irq_len: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(host_alert_oe) |-> $past(cur_ff.irq_cnt) == 32'h0000_0001)
		else $error("alert pulse cut short");
	chk_mask_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		cur_ff.mask[6:0] == 7'h7F && !host_alert_oe |=> !host_alert_oe || !$stable(cur_ff.mask))
		else $error("masked event raised alert");
	chk_tri_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!cur_ff.ctl3[B_TRI_EN] |=> cur_ff.tri_cnt == 32'h0000_0000)
		else $error("trickle timer ran while disabled");
endmodule

// ==== rtl/cbk_pkg.sv ====
// constants and carriers for the charger register bank
// assumes a 100 MHz logic clock and a two-wire host bus
package cbk_pkg;
	// ****************************
	// register offsets and resets
	// ****************************
	localparam logic [7:0] OFS_STAT0 = 8'h00;
	localparam logic [7:0] OFS_ZONE  = 8'h01;
	localparam logic [7:0] OFS_MASK  = 8'h02;
	localparam logic [7:0] OFS_CTL0  = 8'h03;
	localparam logic [7:0] OFS_CTL1  = 8'h04;
	localparam logic [7:0] OFS_CTL2  = 8'h05;
	localparam logic [7:0] OFS_CTL3  = 8'h06;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [7:0] RST_CTL0  = 8'h00;
	localparam logic [7:0] RST_CTL1  = 8'h24;
	localparam logic [7:0] RST_CTL2  = 8'h44;
	localparam logic [7:0] RST_CTL3  = 8'h43;
	localparam logic [2:0] RST_ZONE  = 3'h3;
	localparam logic [6:0] TGT_ADDR  = 7'h6B;
	// ****************************
	// field positions
	// ****************************
	localparam int B_CHG_EN = 7;
	localparam int B_KICK   = 7;
	localparam int B_WD_ON  = 6;
	localparam int B_NTC_ON = 5;
	localparam int B_TRI_EN = 4;
	localparam int B_TERM   = 3;
	localparam logic [1:0] PH_OFF = 2'h0;
	localparam logic [1:0] PH_TRI = 2'h1;
	localparam logic [1:0] PH_CC  = 2'h2;
	localparam logic [1:0] PH_EOC = 2'h3;
	localparam logic [1:0] SW_SYSRST = 2'h1;
	// ****************************
	// timing
	// ****************************
	localparam int CLK_HZ   = 100_000_000;
	localparam int TICK_US  = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int WDOG_S   = 40;
	localparam int OFF_S    = 8;
	localparam int TRI_MIN  = 45;   // 0.75 h
	localparam int FAST_MIN = 225;  // 3.75 h
	localparam int WDOG_TK  = WDOG_S * 1000;
	localparam int OFF_TK   = OFF_S * 1000;
	localparam int TRI_TK   = TRI_MIN * 60_000;
	localparam int FAST_TK  = FAST_MIN * 60_000;
	localparam int IRQ_US   = 256;
	localparam int IRQ_CYC  = IRQ_US * (CLK_HZ / 1_000_000);
	// ****************************
	// carriers
	// ****************************
	typedef struct packed {
		logic       bat_low;
		logic       sys_short;
		logic [1:0] phase;
		logic       pgood;
		logic [2:0] zone;
	} cbk_core_t;
	typedef struct packed {
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [5:0] fast_current_code;
		logic       slow_phase_threshold_select;
		logic       charge_run;
		logic       thermistor_sense_on;
		logic       power_paths_off;
	} cbk_cfg_t;
endpackage

// ==== verif/cbk_bank_tb_top.sv ====
// self-checking bench for the charger register bank
// assumes the host model on the bus pins and shortened timer parameters
`timescale 1ns/10ps
module cbk_bank_tb_top;
	import cbk_pkg::*;
	localparam int TICK = 10;
	localparam int WDOG = 1500;
	localparam int OFFT = 50;
	localparam int IRQN = 16;
	logic      sys_clk;
	logic      srst;
	logic      host_clk;
	logic      host_pull;
	wire       sda_line;
	logic      dat_out;
	logic      dat_oe;
	logic      alert_out;
	logic      alert_oe;
	cbk_core_t core;
	cbk_cfg_t  cfg;
	int        errors;
	int        checked;
	// open-drain data wire with pull-up
	assign sda_line = ~(dat_oe | host_pull);
	cbk_bank #(
		.TICK_CYCLES(TICK), .WDOG_TICKS(WDOG), .OFF_TICKS(OFFT),
		.TRI_TICKS(10), .FAST_TICKS(20), .IRQ_CYCLES(IRQN)
	) dut_u (
		.sys_clk       (sys_clk),
		.srst          (srst),
		.bus_clk       (host_clk),
		.bus_data_in   (sda_line),
		.bus_data_out  (dat_out),
		.bus_data_oe   (dat_oe),
		.host_alert_out(alert_out),
		.host_alert_oe (alert_oe),
		.core          (core),
		.cfg           (cfg)
	);
	cbk_host_model host_u (
		.bus_clk (host_clk),
		.sda_pull(host_pull),
		.sda     (sda_line)
	);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ****************************
	// shared tasks
	// ****************************
	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host_u.reg_read(ptr, d, ok);
		chk("read ack", 8'h01, {7'h00, ok});
		chk($sformatf("register %h", ptr), exp, d);
	endtask
	task automatic wr(input logic [7:0] ptr, input int n, input logic [39:0] d);
		logic ok;
		host_u.reg_write(ptr, n, d, ok);
		chk("write ack", 8'h01, {7'h00, ok});
	endtask
	task automatic set_core(input cbk_core_t c);
		@(posedge sys_clk);
		core <= c;
		cyc(4);
	endtask
	// length of the next alert pulse, 0 if none shows within a few cycles
	task automatic pulse_len(output int n);
		int w;
		n = 0;
		w = 0;
		while (alert_oe !== 1'b1 && w < 4) begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		while (alert_oe === 1'b1 && n < 40) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
	task automatic wait_off(input logic lvl, input int lim, output int n);
		n = 0;
		while (cfg.power_paths_off !== lvl) begin
			@(posedge sys_clk);
			n++;
			if (n > lim) begin
				errors++;
				$display("CHECK FAILED power_paths_off expected %b seen %b", lvl, cfg.power_paths_off);
				report_and_stop();
			end
		end
	endtask
	// ****************************
	// scenarios
	// ****************************
	task automatic s_reset_values();
		logic [7:0] exp [8];
		exp = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h24, 8'h44, 8'h43, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd(i[7:0], exp[i]);
		end
		chk("cfg ctl0", 8'h00, cfg.ctl0);
		chk("cfg ctl1", 8'h24, cfg.ctl1);
		chk("fast code", 8'h04, {2'b00, cfg.fast_current_code});
		chk("threshold", 8'h01, {7'h00, cfg.slow_phase_threshold_select});
		chk("charge run", 8'h00, {7'h00, cfg.charge_run});
		chk("sense on", 8'h00, {7'h00, cfg.thermistor_sense_on});
	endtask
	task automatic s_write_back();
		logic ack;
		host_u.probe(7'h6A, ack);
		chk("foreign ack", 8'h00, {7'h00, ack});
		wr(8'h02, 5, 40'h7F_FAB4_3FF3);
		wr(8'h00, 1, 40'hFF_0000_0000);
		rd(8'h00, 8'h00);
		rd(8'h02, 8'h7F);
		rd(8'h03, 8'hFA);
		rd(8'h04, 8'hB4);
		rd(8'h05, 8'h3F);
		rd(8'h06, 8'h73);
		chk("cfg ctl0", 8'hFA, cfg.ctl0);
		chk("cfg ctl1", 8'hB4, cfg.ctl1);
		chk("fast code", 8'h3F, {2'b00, cfg.fast_current_code});
		chk("threshold", 8'h00, {7'h00, cfg.slow_phase_threshold_select});
		chk("sense on", 8'h01, {7'h00, cfg.thermistor_sense_on});
	endtask
	task automatic s_status_map();
		set_core({1'b1, 1'b0, PH_CC, 1'b1, 3'b100});
		rd(8'h00, 8'h15);
		rd(8'h01, 8'h04);
		set_core({1'b0, 1'b1, PH_TRI, 1'b0, 3'b010});
		rd(8'h00, 8'h0A);
		rd(8'h01, 8'h02);
	endtask
	task automatic s_alert();
		int n;
		wr(8'h02, 1, 40'h00_0000_0000);
		@(posedge sys_clk);
		core.pgood <= 1'b1;
		pulse_len(n);
		chk("alert length", IRQN[7:0], n[7:0]);
		chk("alert level", 8'h00, {7'h00, alert_out});
		wr(8'h02, 1, 40'h04_0000_0000);
		@(posedge sys_clk);
		core.pgood <= 1'b0;
		pulse_len(n);
		chk("masked alert", 8'h00, n[7:0]);
	endtask
	task automatic s_trickle();
		set_core({1'b0, 1'b0, PH_TRI, 1'b1, 3'b011});
		wr(8'h05, 2, 40'hC4_9300_0000);
		chk("charge run", 8'h01, {7'h00, cfg.charge_run});
		cyc(10 * TICK + 50);
		rd(8'h00, 8'h83);
		wr(8'h05, 1, 40'h44_0000_0000);
		chk("charge run", 8'h00, {7'h00, cfg.charge_run});
		rd(8'h00, 8'h03);
		// end of charge with termination on, then off
		set_core({1'b0, 1'b0, PH_EOC, 1'b1, 3'b011});
		wr(8'h06, 1, 40'h0B_0000_0000);
		wr(8'h05, 1, 40'hC4_0000_0000);
		chk("term stop", 8'h00, {7'h00, cfg.charge_run});
		wr(8'h06, 1, 40'h03_0000_0000);
		chk("term off run", 8'h01, {7'h00, cfg.charge_run});
		wr(8'h05, 1, 40'h44_0000_0000);
		set_core({1'b0, 1'b0, PH_TRI, 1'b1, 3'b011});
	endtask
	task automatic s_watchdog();
		int n;
		wr(8'h06, 1, 40'hC3_0000_0000);
		cyc(WDOG * TICK - 6000);
		// host keeps its side: kick well before expiry
		wr(8'h06, 1, 40'hC3_0000_0000);
		wait_off(1'b1, WDOG * TICK + 300, n);
		if (n < WDOG * TICK - 700) begin
			errors++;
			$display("CHECK FAILED watchdog period expected %0d seen %0d", WDOG * TICK, n);
		end
		checked++;
		wait_off(1'b0, OFFT * TICK + 200, n);
		chk("off period", 8'h01, {7'h00, (n >= OFFT * TICK - 20 && n <= OFFT * TICK + 20)});
		rd(8'h05, 8'h44);
		rd(8'h02, 8'h00);
		rd(8'h00, 8'h23);
	endtask
	// ****************************
	// main sequence
	// ****************************
	initial begin
		errors = 0;
		checked = 0;
		srst = 1'b1;
		core = {1'b0, 1'b0, PH_OFF, 1'b0, 3'b011};
		cyc(20);
		srst <= 1'b0;
		cyc(5);
		s_reset_values();
		s_write_back();
		s_status_map();
		s_alert();
		s_trickle();
		s_watchdog();
		report_and_stop();
	end
endmodule

// ==== verif/cbk_host_model.sv ====
// two-wire host model that reaches the charger register bank
// assumes pull-ups on both lines; the bench resolves the data wire
`timescale 1ns/10ps
module cbk_host_model (
	output logic      bus_clk,  // clock pin, idles high
	output logic      sda_pull, // high pulls data low
	input  wire logic sda       // resolved data level
);
	import cbk_pkg::*;
	// quarter bit; link clock period of 80 ns, four logic cycles per clock phase
	localparam int Q = 20;
	initial begin
		bus_clk  = 1'b1;
		sda_pull = 1'b0;
	end
	// ****************************
	// bit level
	// ****************************
	// data moves only while the clock is low
	task automatic put_bit(input logic b);
		#Q sda_pull = ~b;
		#Q bus_clk = 1'b1;
		#(2*Q) bus_clk = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		#Q sda_pull = 1'b0;
		#Q bus_clk = 1'b1;
		#Q b = sda;
		#Q bus_clk = 1'b0;
	endtask
	// also serves as repeated start
	task automatic start_cond();
		#Q sda_pull = 1'b0;
		#Q bus_clk = 1'b1;
		#(2*Q) sda_pull = 1'b1;
		#(2*Q) bus_clk = 1'b0;
	endtask
	task automatic stop_cond();
		#Q sda_pull = 1'b1;
		#Q bus_clk = 1'b1;
		#(2*Q) sda_pull = 1'b0;
		#(2*Q);
	endtask
	// ****************************
	// byte and transfer level
	// ****************************
	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = ~b;
	endtask
	task automatic probe(input logic [6:0] adr, output logic ack);
		start_cond();
		send({adr, 1'b0}, ack);
		stop_cond();
	endtask
	// pointer, then n bytes taken from the top of d
	task automatic reg_write(input logic [7:0] ptr, input int n, input logic [39:0] d, output logic ok);
		logic a;
		start_cond();
		send({TGT_ADDR, 1'b0}, ok);
		send(ptr, a);
		ok = ok & a;
		for (int i = 0; i < n; i++) begin
			send(d[39-8*i -: 8], a);
			ok = ok & a;
		end
		stop_cond();
	endtask
	// single byte read closed by a nack
	task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic a;
		logic b;
		start_cond();
		send({TGT_ADDR, 1'b0}, ok);
		send(ptr, a);
		ok = ok & a;
		start_cond();
		send({TGT_ADDR, 1'b1}, a);
		ok = ok & a;
		for (int i = 7; i >= 0; i--) begin
			get_bit(b);
			d[i] = b;
		end
		put_bit(1'b1);
		stop_cond();
	endtask
endmodule
